// ---- src/gpcs_consts.svh ----
// constants for the gigabit coding sublayer management registers
// assumes a 16-bit management read/write port driven by the station manager
`ifndef GPCS_CONSTS_SVH
`define GPCS_CONSTS_SVH
`define GPCS_REG_CTRL 5'h00
`define GPCS_REG_STAT 5'h01
`define GPCS_REG_ID_HI 5'h02
`define GPCS_REG_ID_LO 5'h03
`define GPCS_REG_ADV 5'h04
`define GPCS_REG_LPA 5'h05
`define GPCS_REG_EXP 5'h06
`define GPCS_REG_NPTX 5'h07
`define GPCS_REG_NPRX 5'h08
`define GPCS_REG_EXTST 5'h0f
`define GPCS_REG_ANIRQ 5'h10
`define GPCS_REG_LOOP 5'h11
`define GPCS_C_RESET 15
`define GPCS_C_LOOP 14
`define GPCS_C_ANEN 12
`define GPCS_C_PWRDN 11
`define GPCS_C_ISOL 10
`define GPCS_C_ANRST 9
`define GPCS_C_UNIDIR 5
`define GPCS_CTRL_FIXED 16'h0140
`define GPCS_STAT_FIXED 16'h01c8
`define GPCS_S_ANDONE 5
`define GPCS_S_RFAULT 4
`define GPCS_S_LINK 2
`define GPCS_I_STAT 1
`define GPCS_I_EN 0
`define GPCS_EXTST_VAL 16'h8000
`define GPCS_EXP_FIXED 16'h0004
`define GPCS_ADV_RST 16'h01a0
`define GPCS_ADV_WMASK 16'hb1a0
`define GPCS_NPTX_RST 16'h2001
`define GPCS_NPTX_WMASK 16'hb7ff
`define GPCS_PHY_IF_1000X 3'h5
`define GPCS_IDLE_K 10'h0fa
`define GPCS_IDLE_D 10'h16a
`define GPCS_ST_RST 4'h0
`define GPCS_LOOP_RST 1'b0
`define GPCS_ANEN_RST 1'b1
`define GPCS_PWRDN_RST 1'b0
`define GPCS_ISOL_RST 1'b1
`define GPCS_UNIDIR_RST 1'b0
`define GPCS_IRQEN_RST 1'b1
`define GPCS_RD_RST 16'h0000
`define GPCS_RXSYM_RST 10'h000
`endif

// ---- src/gpcs_pkg.sv ----
// types for the gigabit coding sublayer management block
package gpcs_pkg;
  typedef enum logic [1:0] {
    GPCS_AN_IDLE = 2'h0,
    GPCS_AN_RUN = 2'h1,
    GPCS_AN_DONE = 2'h3
  } gpcs_an_t;
endpackage

// ---- src/gpcs_mgmt_regs.sv ----
// management registers and loopback point of the 1000BASE-X coding sublayer
// assumes a management interface delivering one-cycle read/write strobes on clk,
// and link-side symbol streams clocked by linkClk
//
// Overview of operation
// R1: writing 1 to control bit 15 resets the sublayer; bit self-clears
// R2: control bit 14 read/write, reset 0, enables loopback
// R3: loopback routes transmit symbols to receive path just before transceiver
// R4: during loopback an unbroken Idle stream goes to the transceiver
// R5: control bit 13 reads 0 and bit 6 reads 1: fixed gigabit speed
// R6: control bit 12 read/write, reset 1, enables auto-negotiation
// R7: control bit 11 sets power down; only sublayer reset clears it
// R8: control bit 10 read/write, reset 1, isolates the physical layer
// R9: station must clear isolate before the core operates
// R10: writing 1 to control bit 9 restarts auto-negotiation; self-clears
// R11: control bit 8 always reads 1, full duplex; writes ignored
// R12: control bit 7 and bits 4..0 always read 0
// R13: control bit 5 read/write, reset 0, allows transmit without link
// R14: status bits 15..9 always read 0
// R15: status bits 8 and 7 always read 1
// R16: status bit 6 always reads 1, preamble suppression accepted
// R17: status bit 5 shows auto-negotiation complete, reset 0
// R18: status bit 4 reports remote fault; clears when status is read
// R19: status bit 3 always reads 1, auto-negotiation capable
// R20: decode addresses 0, 1, 4..8, 15 and 16
// R21: software polls completion bit or services the completion interrupt
// R22: registers are meaningful only with the 1000BASE-X interface selected
// R23: register 16 bit 1 set on completion if enabled; cleared by writing 0
// R24: register 16 bit 0 read/write, reset 1, interrupt enable
// R25: status bit 2 reports link up; clears when status is read
// R26: undefined addresses read zero and ignore writes
`timescale 1ns/1ps
`include "gpcs_consts.svh"
module gpcs_mgmt_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] phyInterfaceParam,
  input wire logic [4:0] mgmtRegSelect,
  input wire logic mgmtWrStb,
  input wire logic mgmtRdStb,
  input wire logic [15:0] mgmtWrData,
  output logic [15:0] mgmtRdData,
  input wire logic anComplete,
  input wire logic remoteFault,
  input wire logic linkUp,
  input wire logic pageReceived,
  input wire logic [15:0] partnerAbility,
  input wire logic [15:0] nextPageRx,
  output logic anRestartPulse,
  output logic anEnable,
  output logic anIrq,
  output logic unidirEnable,
  output logic isolate,
  output logic powerDown,
  output logic sublayerReset,
  input wire logic linkClk,
  input wire logic [9:0] txSymbol,
  input wire logic [9:0] serdesRxSymbol,
  output logic [9:0] serdesTxSymbol,
  output logic [9:0] rxSymbol
);
  // valid only with the 1000BASE-X interface; other modes read zero
  logic modeOk;
  assign modeOk = (phyInterfaceParam == `GPCS_PHY_IF_1000X); // R22

  logic wrOk;
  logic rdOk;
  assign wrOk = mgmtWrStb && modeOk;
  assign rdOk = mgmtRdStb && modeOk;

  // status inputs come from the link side: two flops each
  logic [3:0] stMeta_q;
  logic [3:0] stSync_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stMeta_q <= `GPCS_ST_RST;
      stSync_q <= `GPCS_ST_RST;
    end else begin
      stMeta_q <= {pageReceived, linkUp, remoteFault, anComplete};
      stSync_q <= stMeta_q;
    end
  end
  logic anDoneS;
  logic rfaultS;
  logic linkS;
  logic pageS;
  assign anDoneS = stSync_q[0];
  assign rfaultS = stSync_q[1];
  assign linkS = stSync_q[2];
  assign pageS = stSync_q[3];

  // edge detect reads only the second flop, so no unsettled value leaks in
  logic anDonePrev_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anDonePrev_q <= 1'b0;
    end else begin
      anDonePrev_q <= anDoneS;
    end
  end
  logic anDoneRise;
  assign anDoneRise = anDoneS && !anDonePrev_q;

  // control register
  logic loop_q;
  logic anEn_q;
  logic pwrDn_q;
  logic isol_q;
  logic unidir_q;
  logic softRst_q;
  logic anRst_q;
  logic ctrlWr;
  assign ctrlWr = wrOk && (mgmtRegSelect == `GPCS_REG_CTRL);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_q <= `GPCS_LOOP_RST;
      anEn_q <= `GPCS_ANEN_RST;
      pwrDn_q <= `GPCS_PWRDN_RST;
      isol_q <= `GPCS_ISOL_RST;
      unidir_q <= `GPCS_UNIDIR_RST;
    end else if (softRst_q) begin
      loop_q <= `GPCS_LOOP_RST; // R1
      anEn_q <= `GPCS_ANEN_RST;
      pwrDn_q <= `GPCS_PWRDN_RST; // R7
      isol_q <= `GPCS_ISOL_RST;
      unidir_q <= `GPCS_UNIDIR_RST;
    end else if (ctrlWr) begin
      loop_q <= mgmtWrData[`GPCS_C_LOOP]; // R2
      anEn_q <= mgmtWrData[`GPCS_C_ANEN]; // R6
      // power down can be set by a write but never cleared by one
      pwrDn_q <= pwrDn_q | mgmtWrData[`GPCS_C_PWRDN]; // R7
      isol_q <= mgmtWrData[`GPCS_C_ISOL]; // R8
      unidir_q <= mgmtWrData[`GPCS_C_UNIDIR]; // R13
    end
  end

  // self-clearing strobes: held one cycle then read back as 0
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      softRst_q <= 1'b0;
      anRst_q <= 1'b0;
    end else begin
      softRst_q <= ctrlWr && mgmtWrData[`GPCS_C_RESET]; // R1
      anRst_q <= ctrlWr && mgmtWrData[`GPCS_C_ANRST]; // R10
    end
  end

  // sticky read-clear status bits; a new event beats the clearing read
  logic rfault_q;
  logic link_q;
  logic page_q;
  logic statRd;
  logic expRd;
  assign statRd = rdOk && (mgmtRegSelect == `GPCS_REG_STAT);
  assign expRd = rdOk && (mgmtRegSelect == `GPCS_REG_EXP);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rfault_q <= 1'b0;
      link_q <= 1'b0;
      page_q <= 1'b0;
    end else if (softRst_q) begin
      rfault_q <= 1'b0;
      link_q <= 1'b0;
      page_q <= 1'b0;
    end else begin
      rfault_q <= rfaultS | (rfault_q & ~statRd); // R18
      link_q <= linkS | (link_q & ~statRd); // R25
      page_q <= pageS | (page_q & ~expRd);
    end
  end

  // completion tracking
  gpcs_pkg::gpcs_an_t anState_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anState_q <= gpcs_pkg::GPCS_AN_IDLE;
    end else if (softRst_q || anRst_q || !anEn_q) begin
      // a restart or disable drops an earlier result at once
      anState_q <= gpcs_pkg::GPCS_AN_IDLE;
    end else begin
      case (anState_q)
        gpcs_pkg::GPCS_AN_IDLE: begin
          anState_q <= gpcs_pkg::GPCS_AN_RUN;
        end
        gpcs_pkg::GPCS_AN_RUN: begin
          if (anDoneS) begin
            anState_q <= gpcs_pkg::GPCS_AN_DONE;
          end
        end
        gpcs_pkg::GPCS_AN_DONE: begin
          if (!anDoneS) begin
            anState_q <= gpcs_pkg::GPCS_AN_RUN;
          end
        end
        default: begin
          anState_q <= gpcs_pkg::GPCS_AN_IDLE;
        end
      endcase
    end
  end
  logic anDoneBit;
  assign anDoneBit = (anState_q == gpcs_pkg::GPCS_AN_DONE); // R17

  // interrupt control register 16
  logic irqEn_q;
  logic irqStat_q;
  logic irqWr;
  assign irqWr = wrOk && (mgmtRegSelect == `GPCS_REG_ANIRQ);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEn_q <= `GPCS_IRQEN_RST;
    end else if (irqWr) begin
      irqEn_q <= mgmtWrData[`GPCS_I_EN]; // R24
    end
  end
  // set beats a clearing write in the same cycle, so no completion is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStat_q <= 1'b0;
    end else if (!irqEn_q) begin
      irqStat_q <= 1'b0; // R23
    end else if (anDoneRise) begin
      irqStat_q <= 1'b1; // R23
    end else if (irqWr && !mgmtWrData[`GPCS_I_STAT]) begin
      irqStat_q <= 1'b0; // R23
    end
  end

  // writable auto-negotiation pages
  logic [15:0] adv_q;
  logic [15:0] nptx_q;
  logic advWr;
  logic nptxWr;
  assign advWr = wrOk && (mgmtRegSelect == `GPCS_REG_ADV);
  assign nptxWr = wrOk && (mgmtRegSelect == `GPCS_REG_NPTX);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adv_q <= `GPCS_ADV_RST;
    end else if (advWr) begin
      adv_q <= mgmtWrData & `GPCS_ADV_WMASK;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nptx_q <= `GPCS_NPTX_RST;
    end else if (nptxWr) begin
      nptx_q <= mgmtWrData & `GPCS_NPTX_WMASK;
    end
  end

  // read mux; data registered, valid the cycle after the read strobe
  logic [15:0] rdMux;
  always_comb begin
    rdMux = 16'h0000;
    case (mgmtRegSelect) // R20
      `GPCS_REG_CTRL: begin
        rdMux = `GPCS_CTRL_FIXED; // R5 R11 R12
        rdMux[`GPCS_C_LOOP] = loop_q;
        rdMux[`GPCS_C_ANEN] = anEn_q;
        rdMux[`GPCS_C_PWRDN] = pwrDn_q;
        rdMux[`GPCS_C_ISOL] = isol_q;
        rdMux[`GPCS_C_UNIDIR] = unidir_q;
      end
      `GPCS_REG_STAT: begin
        rdMux = `GPCS_STAT_FIXED; // R14 R15 R16 R19
        rdMux[`GPCS_S_ANDONE] = anDoneBit; // R17
        rdMux[`GPCS_S_RFAULT] = rfault_q; // R18
        rdMux[`GPCS_S_LINK] = link_q; // R25
      end
      `GPCS_REG_ADV: begin
        rdMux = adv_q;
      end
      `GPCS_REG_LPA: begin
        rdMux = partnerAbility;
      end
      `GPCS_REG_EXP: begin
        rdMux = `GPCS_EXP_FIXED | {14'h0000, page_q, 1'b0};
      end
      `GPCS_REG_NPTX: begin
        rdMux = nptx_q;
      end
      `GPCS_REG_NPRX: begin
        rdMux = nextPageRx;
      end
      `GPCS_REG_EXTST: begin
        rdMux = `GPCS_EXTST_VAL;
      end
      `GPCS_REG_ANIRQ: begin
        rdMux = {14'h0000, irqStat_q, irqEn_q};
      end
      default: begin
        rdMux = 16'h0000; // R26
      end
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mgmtRdData <= `GPCS_RD_RST;
    end else if (rdOk) begin
      mgmtRdData <= rdMux;
    end else if (mgmtRdStb) begin
      mgmtRdData <= `GPCS_RD_RST; // R22
    end
  end

  assign anRestartPulse = anRst_q; // R10
  assign sublayerReset = softRst_q; // R1
  assign anEnable = anEn_q;
  assign anIrq = irqStat_q;
  assign unidirEnable = unidir_q;
  assign isolate = isol_q; // R9
  assign powerDown = pwrDn_q;

  // link-side reset: asserted at once, released only after two link edges
  logic linkRstMeta_q;
  logic linkRst_q;
  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      linkRstMeta_q <= 1'b1;
      linkRst_q <= 1'b1;
    end else begin
      linkRstMeta_q <= 1'b0;
      linkRst_q <= linkRstMeta_q;
    end
  end

  // loopback level crosses into the link domain
  logic loopMeta_q;
  logic loopLink_q;
  always_ff @(posedge linkClk or posedge linkRst_q) begin
    if (linkRst_q) begin
      loopMeta_q <= `GPCS_LOOP_RST;
      loopLink_q <= `GPCS_LOOP_RST;
    end else begin
      loopMeta_q <= loop_q;
      loopLink_q <= loopMeta_q;
    end
  end

  // idle ordered set alternates comma and data symbol; parity of a real
  // encoder is not tracked here, a limitation of this loop point
  logic idlePhase_q;
  always_ff @(posedge linkClk or posedge linkRst_q) begin
    if (linkRst_q) begin
      idlePhase_q <= 1'b0;
    end else begin
      idlePhase_q <= ~idlePhase_q;
    end
  end

  always_ff @(posedge linkClk or posedge linkRst_q) begin
    if (linkRst_q) begin
      serdesTxSymbol <= `GPCS_IDLE_K;
      rxSymbol <= `GPCS_RXSYM_RST;
    end else if (loopLink_q) begin
      serdesTxSymbol <= idlePhase_q ? `GPCS_IDLE_D : `GPCS_IDLE_K; // R4
      rxSymbol <= txSymbol; // R3
    end else begin
      serdesTxSymbol <= txSymbol;
      rxSymbol <= serdesRxSymbol;
    end
  end
endmodule // gpcs_mgmt_regs

// ---- sim/gpcs_mgmt_regs_asserts.sv ----
// checker for the coding sublayer management registers
// sees only the top module ports; bound below
`timescale 1ns/1ps
module gpcs_mgmt_regs_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] phyInterfaceParam,
  input wire logic [4:0] mgmtRegSelect,
  input wire logic mgmtWrStb,
  input wire logic mgmtRdStb,
  input wire logic [15:0] mgmtWrData,
  input wire logic [15:0] mgmtRdData,
  input wire logic anRestartPulse,
  input wire logic anEnable,
  input wire logic unidirEnable,
  input wire logic isolate,
  input wire logic powerDown,
  input wire logic sublayerReset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic modeOn;
  logic ctrlWr;
  logic rdOn;
  assign modeOn = phyInterfaceParam == 3'h5;
  assign ctrlWr = mgmtWrStb && modeOn && mgmtRegSelect == 5'h00;
  assign rdOn = mgmtRdStb && modeOn;
  a_reset_pulse: assert property (ctrlWr && mgmtWrData[15] |=> sublayerReset ##1 !sublayerReset)
    else $error("soft reset pulse wrong");
  a_restart_pulse: assert property (ctrlWr && mgmtWrData[9] && !mgmtWrData[15] |=>
    anRestartPulse ##1 !anRestartPulse) else $error("restart pulse wrong");
  a_ctrl_write: assert property (ctrlWr && !mgmtWrData[15] |=> anEnable == $past(mgmtWrData[12])
    && isolate == $past(mgmtWrData[10]) && unidirEnable == $past(mgmtWrData[5]))
    else $error("control field not written");
  a_pwrdn_set: assert property (ctrlWr && mgmtWrData[11] && !mgmtWrData[15] |=> powerDown)
    else $error("power down not set");
  // a write of 0 must not release power down; only the soft reset may
  a_pwrdn_hold: assert property (powerDown && !sublayerReset && !(ctrlWr && mgmtWrData[15]) |=> powerDown)
    else $error("power down dropped");
  a_ctrl_fixed: assert property (rdOn && mgmtRegSelect == 5'h00 |=> mgmtRdData[13] == 1'b0
    && mgmtRdData[8:6] == 3'h5 && mgmtRdData[4:0] == 5'h00) else $error("control fixed bits");
  a_stat_fixed: assert property (rdOn && mgmtRegSelect == 5'h01 |=>
    mgmtRdData[15:6] == 10'h007 && mgmtRdData[3]) else $error("status fixed bits");
  a_undef_zero: assert property (rdOn && mgmtRegSelect > 5'h08 && mgmtRegSelect < 5'h0f |=>
    mgmtRdData == 16'h0000) else $error("undefined address not zero");
  a_mode_off: assert property (mgmtRdStb && !modeOn |=> mgmtRdData == 16'h0000)
    else $error("read outside gigabit mode not zero");
endmodule // gpcs_mgmt_regs_asserts
bind gpcs_mgmt_regs gpcs_mgmt_regs_asserts chk (.clk, .sys_rst, .phyInterfaceParam, .mgmtRegSelect,
  .mgmtWrStb, .mgmtRdStb, .mgmtWrData, .mgmtRdData, .anRestartPulse, .anEnable, .unidirEnable,
  .isolate, .powerDown, .sublayerReset);

// ---- sim/gpcs_link_model.sv ----
// link-side partner: transmit symbol source and transceiver receive stream
// runs on linkClk only; sys_rst gives it a known start
`timescale 1ns/1ps
module gpcs_link_model (
  input wire logic linkClk,
  input wire logic sys_rst,
  output logic [9:0] txSymbol,
  output logic [9:0] serdesRxSymbol
);
  // a counting source makes the one-edge loop delay easy to predict
  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      txSymbol <= 10'h000;
      serdesRxSymbol <= 10'h155;
    end else begin
      txSymbol <= txSymbol + 10'h001;
      serdesRxSymbol <= ~serdesRxSymbol;
    end
  end
endmodule // gpcs_link_model

// ---- sim/gpcs_mgmt_regs_tb_top.sv ----
// self-checking bench for the management registers and loopback point
// expects the design, its checker bind and the link partner model
`timescale 1ns/1ps
module gpcs_mgmt_regs_tb_top;
  logic clk, sys_rst, linkClk, mgmtWrStb, mgmtRdStb, anComplete, remoteFault, linkUp, pageReceived;
  logic anRestartPulse, anEnable, anIrq, unidirEnable, isolate, powerDown, sublayerReset;
  logic [2:0] phyInterfaceParam;
  logic [4:0] mgmtRegSelect;
  logic [15:0] mgmtWrData, mgmtRdData, partnerAbility, nextPageRx;
  logic [9:0] txSymbol, serdesRxSymbol, serdesTxSymbol, rxSymbol, s1;
  int fails, comparisons;
  gpcs_mgmt_regs uut (.clk, .sys_rst, .phyInterfaceParam, .mgmtRegSelect, .mgmtWrStb, .mgmtRdStb,
    .mgmtWrData, .mgmtRdData, .anComplete, .remoteFault, .linkUp, .pageReceived,
    .partnerAbility, .nextPageRx, .anRestartPulse, .anEnable, .anIrq, .unidirEnable, .isolate,
    .powerDown, .sublayerReset, .linkClk, .txSymbol, .serdesRxSymbol, .serdesTxSymbol, .rxSymbol);
  gpcs_link_model link (.linkClk, .sys_rst, .txSymbol, .serdesRxSymbol);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #7.5 linkClk = ~linkClk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmtRegSelect <= a;
    mgmtWrData <= d;
    mgmtWrStb <= 1'b1;
    @(posedge clk);
    mgmtWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    mgmtRegSelect <= a;
    mgmtRdStb <= 1'b1;
    @(posedge clk);
    mgmtRdStb <= 1'b0;
    #1 chk(mgmtRdData, e);
  endtask
  task automatic final_report;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a whole run is about a hundred core cycles; this leaves ample margin
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    phyInterfaceParam = 3'h5;
    mgmtRegSelect = 5'h00;
    mgmtWrData = 16'h0000;
    mgmtWrStb = 1'b0;
    mgmtRdStb = 1'b0;
    anComplete = 1'b0;
    remoteFault = 1'b0;
    linkUp = 1'b0;
    pageReceived = 1'b0;
    partnerAbility = 16'ha5a5;
    nextPageRx = 16'h5a5a;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(5'h00, 16'h1540);
    rd(5'h01, 16'h01c8);
    rd(5'h10, 16'h0001);
    rd(5'h0f, 16'h8000);
    rd(5'h05, 16'ha5a5);
    rd(5'h08, 16'h5a5a);
    wr(5'h0a, 16'hffff);
    for (int a = 9; a < 15; a++) begin
      rd(a[4:0], 16'h0000);
    end
    rd(5'h11, 16'h0000);
    wr(5'h00, 16'h4820);
    rd(5'h00, 16'h4960);
    wr(5'h00, 16'h4020);
    rd(5'h00, 16'h4960);
    repeat (4) @(posedge linkClk);
    #1 s1 = serdesTxSymbol;
    chk({6'h00, rxSymbol}, {6'h00, txSymbol - 10'h001});
    @(posedge linkClk);
    #1 chk({6'h00, s1 ^ serdesTxSymbol}, 16'h0190);
    chk({6'h00, s1} + {6'h00, serdesTxSymbol}, 16'h0264);
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h1540);
    wr(5'h00, 16'h1200);
    rd(5'h00, 16'h1140);
    @(posedge clk);
    linkUp <= 1'b1;
    remoteFault <= 1'b1;
    pageReceived <= 1'b1;
    repeat (4) @(posedge clk);
    linkUp <= 1'b0;
    remoteFault <= 1'b0;
    pageReceived <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h01, 16'h01dc);
    rd(5'h01, 16'h01c8);
    rd(5'h06, 16'h0006);
    rd(5'h06, 16'h0004);
    @(posedge clk);
    anComplete <= 1'b1;
    repeat (5) @(posedge clk);
    rd(5'h01, 16'h01e8);
    rd(5'h10, 16'h0003);
    chk({15'h0000, anIrq}, 16'h0001);
    wr(5'h10, 16'h0001);
    rd(5'h10, 16'h0001);
    wr(5'h10, 16'h0000);
    rd(5'h10, 16'h0000);
    @(posedge clk);
    phyInterfaceParam <= 3'h4;
    rd(5'h00, 16'h0000);
    final_report();
  end
endmodule // gpcs_mgmt_regs_tb_top
